// ===== design/pdb_defines.svh
// Offsets, field positions, reset values and timing counts of the parity DRAM board control
`ifndef PDB_DEFINES_SVH
`define PDB_DEFINES_SVH

`define PDB_CLK_NS        25
`define PDB_T_ACC_NS      200
`define PDB_ACC_CYC       (`PDB_T_ACC_NS / `PDB_CLK_NS)
`define PDB_T_WR_NS       50
`define PDB_WR_CYC        (`PDB_T_WR_NS / `PDB_CLK_NS)
`define PDB_T_REF_NS      400
`define PDB_REF_CYC       ((`PDB_T_REF_NS + `PDB_CLK_NS - 1) / `PDB_CLK_NS)
`define PDB_T_REF_INT_NS  15600
`define PDB_REF_INT_CYC   (`PDB_T_REF_INT_NS / `PDB_CLK_NS)

`define PDB_OFS_STATUS    8'h00
`define PDB_OFS_CLEAR     8'h04
`define PDB_OFS_ENABLE    8'h08
`define PDB_OFS_CFG       8'h0c
`define PDB_OFS_ERR0      8'h10
`define PDB_OFS_ERR1      8'h14

`define PDB_CFG_RST       32'h0000_0001
`define PDB_CFG_TWO_REGS  0
`define PDB_CFG_REF_EXT   1
`define PDB_CFG_PAR_EXT   2
`define PDB_CFG_ADV_EN    3
`define PDB_CFG_ADV_LO    4
`define PDB_CFG_INT0_EN   6
`define PDB_CFG_INT1_EN   7
`define PDB_CFG_INT0_LO   8
`define PDB_CFG_INT1_LO   11
`define PDB_CFG_IO_LO     16

`define PDB_ERR_LANE_LO   16
`define PDB_ERR_VALID     31

`endif

// ===== design/pdb_pkg.sv
// Types shared by the parity DRAM board control
package pdb_pkg;
    typedef enum logic [2:0] {
        PDB_IDLE,
        PDB_REFRESH,
        PDB_ACCESS,
        PDB_ACK,
        PDB_HOLD
    } pdb_state_t;
endpackage : pdb_pkg

// ===== design/pdb_lane_par.sv
// Parity generator and checker for one byte lane
`timescale 1ns/10ps
module pdb_lane_par #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] data,
    input  wire logic         stored,
    output logic              par,
    output logic              bad
);
    assign par = ^data;
    assign bad = par ^ stored;
endmodule : pdb_lane_par

// ===== design/pdb_dram_ctrl.sv
// Parity DRAM board control: address decode, array, parity, error registers, refresh, APB registers
// Operation
// RQ1: Base address comes from three hex switches, 4K byte resolution.
// RQ2: Base equals switch value followed by three zero hex digits, anywhere.
// RQ3: Serve byte and word transfers from 8-bit and 16-bit masters.
// RQ4: Compute and store parity with every write.
// RQ5: Recompute and compare parity on every read.
// RQ6: On read mismatch an error register captures row and bank.
// RQ7: Parity error raises bus interrupt and lights the LED.
// RQ8: Each error register has own routable, disableable interrupt line.
// RQ9: One or two error registers are used, by configuration.
// RQ10: Error status readable at a selectable I/O port address.
// RQ11: Refresh from on-board timer or external request, by configuration.
// RQ12: Parity source is internal generator or external input.
// RQ13: Optional advanced acknowledge with selectable advance.
// RQ14: Respond only within base to base plus capacity.
// RQ15: An access arriving during refresh waits for refresh to finish.
`timescale 1ns/10ps
`include "pdb_defines.svh"
module pdb_dram_ctrl import pdb_pkg::*; #(
    parameter int AW      = 14,
    parameter int ROW_W   = 7,
    parameter int REF_INT = `PDB_REF_INT_CYC
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ,
    input  wire logic [11:0] SW_BASE,
    input  wire logic        MEM_REQ,
    input  wire logic        MEM_IO,
    input  wire logic        MEM_WR,
    input  wire logic [23:0] MEM_ADDR,
    input  wire logic [1:0]  MEM_BE,
    input  wire logic [15:0] MEM_WDATA,
    output logic      [15:0] MEM_RDATA,
    output logic             MEM_ACK,
    input  wire logic        REF_EXT_REQ,
    input  wire logic [1:0]  PAR_EXT,
    output logic      [7:0]  INT_LINE,
    output logic             ERR_LED
);
    localparam int ACC_CYC = `PDB_ACC_CYC;
    localparam int CHK_RD_DLY = `PDB_ACC_CYC + 1;

    logic [17:0]  mem_r [2**AW];
    pdb_state_t   st_r;
    logic [4:0]   cnt_r;
    logic [15:0]  ref_cnt_r;
    logic         ref_pend_r;
    logic [31:0]  cfg_r;
    logic [1:0]   stat_r;
    logic [1:0]   en_r;
    logic [31:0]  err0_r;
    logic [31:0]  err1_r;
    logic [15:0]  rdata_r;
    logic [7:0]   int_r;
    logic         led_r;

    logic [24:0]  base;
    logic [24:0]  addr_ext;
    logic         hit;
    logic         io_hit;
    logic [AW-1:0] idx;
    logic [17:0]  word;
    logic [1:0]   gen_par;
    logic [1:0]   bad;
    logic [1:0]   lane_bad;
    logic         launch;
    logic         launch_rd;
    logic         launch_wr;
    logic [1:0]   stat_set;
    logic [1:0]   stat_clr;
    logic [4:0]   wait_cyc;
    logic [1:0]   adv;
    logic         wr_acc;
    logic         rd_acc;
    logic         apb_hit;
    logic [31:0]  err_info;

    assign base     = {1'b0, SW_BASE, 12'h000}; // RQ1 RQ2
    assign addr_ext = {1'b0, MEM_ADDR};
    assign hit      = (addr_ext >= base) && (addr_ext < base + 25'((2**AW) * 2)); // RQ14
    assign io_hit   = MEM_IO && (MEM_ADDR[7:0] == cfg_r[`PDB_CFG_IO_LO +: 8]); // RQ10
    assign idx      = AW'((addr_ext - base) >> 1);
    assign word     = mem_r[idx];
    assign adv      = cfg_r[`PDB_CFG_ADV_LO +: 2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            pdb_lane_par #(.W(8)) u_par (
                .data   (st_r == PDB_IDLE && MEM_WR ? MEM_WDATA[8*g +: 8] : word[8*g +: 8]),
                .stored (word[16+g]),
                .par    (gen_par[g]),
                .bad    (bad[g])
            );
        end
    endgenerate

    assign launch    = (st_r == PDB_IDLE) && !ref_pend_r && MEM_REQ && !MEM_IO && hit; // RQ15
    assign launch_rd = launch && !MEM_WR;
    assign launch_wr = launch && MEM_WR;
    assign lane_bad  = launch_rd ? (bad & MEM_BE) : 2'b00; // RQ5 RQ3
    assign err_info  = 32'({lane_bad, 16'(idx)});

    // Write-ack or read-ack wait, the read wait shortened by the configured advance
    always_comb begin
        wait_cyc = 5'(ACC_CYC);
        if (MEM_WR) begin
            wait_cyc = 5'(`PDB_WR_CYC);
        end else if (cfg_r[`PDB_CFG_ADV_EN]) begin
            wait_cyc = 5'(ACC_CYC) - {3'b000, adv}; // RQ13
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_r  <= PDB_IDLE;
            cnt_r <= 5'h00;
        end else begin
            case (st_r)
                PDB_IDLE: begin
                    if (ref_pend_r) begin
                        st_r  <= PDB_REFRESH; // RQ15
                        cnt_r <= 5'(`PDB_REF_CYC - 1);
                    end else if (launch) begin
                        st_r  <= PDB_ACCESS;
                        cnt_r <= wait_cyc - 5'h01;
                    end else if (MEM_REQ && io_hit) begin
                        st_r <= PDB_ACK;
                    end
                end
                PDB_REFRESH, PDB_ACCESS: begin
                    if (cnt_r == 5'h00) begin
                        st_r <= (st_r == PDB_REFRESH) ? PDB_IDLE : PDB_ACK;
                    end else begin
                        cnt_r <= cnt_r - 5'h01;
                    end
                end
                PDB_ACK: st_r <= PDB_HOLD;
                PDB_HOLD: begin
                    if (!MEM_REQ) begin
                        st_r <= PDB_IDLE;
                    end
                end
                default: st_r <= PDB_IDLE;
            endcase
        end
    end

    assign MEM_ACK = (st_r == PDB_ACK);

    // Array write with lane enables and stored parity
    always_ff @(posedge CLK_SYS) begin
        if (launch_wr) begin
            for (int i = 0; i < 2; i++) begin
                if (MEM_BE[i]) begin
                    mem_r[idx][8*i +: 8] <= MEM_WDATA[8*i +: 8]; // RQ3
                    mem_r[idx][16+i]     <= cfg_r[`PDB_CFG_PAR_EXT] ? PAR_EXT[i] : gen_par[i]; // RQ4 RQ12
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rdata_r <= 16'h0000;
        end else if (launch_rd) begin
            rdata_r <= word[15:0];
        end else if (st_r == PDB_IDLE && MEM_REQ && io_hit && !ref_pend_r && !launch) begin
            rdata_r <= {14'h0000, stat_r}; // RQ10
        end
    end

    assign MEM_RDATA = rdata_r;

    // Refresh timer or external request; a new request wins over the take
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ref_cnt_r  <= 16'h0000;
            ref_pend_r <= 1'b0;
        end else begin
            ref_cnt_r <= (ref_cnt_r == 16'(REF_INT - 1)) ? 16'h0000 : ref_cnt_r + 16'h0001;
            if (cfg_r[`PDB_CFG_REF_EXT] ? REF_EXT_REQ : (ref_cnt_r == 16'(REF_INT - 1))) begin
                ref_pend_r <= 1'b1; // RQ11
            end else if (st_r == PDB_IDLE) begin
                ref_pend_r <= 1'b0;
            end
        end
    end

    // Error capture: first error to register 0, next to register 1 when two are used
    assign stat_set[0] = (|lane_bad) && !stat_r[0];
    assign stat_set[1] = (|lane_bad) && stat_r[0] && !stat_r[1] && cfg_r[`PDB_CFG_TWO_REGS]; // RQ9
    assign apb_hit = PSEL && PENABLE && PWRITE;
    assign stat_clr = (apb_hit && PADDR == `PDB_OFS_CLEAR) ? PWDATA[1:0] : 2'b00;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            stat_r <= 2'b00;
            err0_r <= 32'h0000_0000;
            err1_r <= 32'h0000_0000;
        end else begin
            stat_r <= stat_set | (stat_r & ~stat_clr);
            if (stat_set[0]) begin
                err0_r <= err_info; // RQ6
            end
            if (stat_set[1]) begin
                err1_r <= err_info; // RQ6
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cfg_r <= `PDB_CFG_RST;
            en_r  <= 2'b00;
        end else if (apb_hit) begin
            if (PADDR == `PDB_OFS_CFG) begin
                cfg_r <= PWDATA;
            end
            if (PADDR == `PDB_OFS_ENABLE) begin
                en_r <= PWDATA[1:0];
            end
        end
    end

    // Bus interrupt lines and indicator
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            int_r <= 8'h00;
            led_r <= 1'b0;
        end else begin
            int_r <= 8'h00;
            if (stat_r[0] && cfg_r[`PDB_CFG_INT0_EN]) begin
                int_r[cfg_r[`PDB_CFG_INT0_LO +: 3]] <= 1'b1; // RQ8 RQ7
            end
            if (stat_r[1] && cfg_r[`PDB_CFG_INT1_EN]) begin
                int_r[cfg_r[`PDB_CFG_INT1_LO +: 3]] <= 1'b1; // RQ8
            end
            led_r <= |stat_r; // RQ7
        end
    end

    assign INT_LINE = int_r;
    assign ERR_LED  = led_r;
    assign IRQ      = |(stat_r & en_r);

    // APB read mux and decode
    always_comb begin
        PRDATA  = 32'h0000_0000;
        PSLVERR = 1'b0;
        case (PADDR)
            `PDB_OFS_STATUS: PRDATA = {30'h0000_0000, stat_r};
            `PDB_OFS_CLEAR:  PRDATA = 32'h0000_0000;
            `PDB_OFS_ENABLE: PRDATA = {30'h0000_0000, en_r};
            `PDB_OFS_CFG:    PRDATA = cfg_r;
            `PDB_OFS_ERR0:   PRDATA = err0_r | (32'(stat_r[0]) << `PDB_ERR_VALID);
            `PDB_OFS_ERR1:   PRDATA = err1_r | (32'(stat_r[1]) << `PDB_ERR_VALID);
            default:         PSLVERR = PSEL && PENABLE;
        endcase
    end

    assign PREADY = 1'b1;

    chk_decode_miss: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ14
        (st_r == PDB_IDLE && MEM_REQ && !MEM_IO && !hit) |=> st_r != PDB_ACCESS)
        else $error("access started outside board range");
    chk_refresh_holdoff: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ15
        (st_r == PDB_IDLE && ref_pend_r) |=> st_r == PDB_REFRESH && !MEM_ACK)
        else $error("access served before pending refresh");
    chk_write_parity: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ4
        (launch_wr && MEM_BE[0] && !cfg_r[`PDB_CFG_PAR_EXT]) |=> mem_r[$past(idx)][16] == ^$past(MEM_WDATA[7:0]))
        else $error("stored parity does not match written byte");
    chk_err_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ6
        (launch_rd && (|(bad & MEM_BE)) && !stat_r[0]) |=> stat_r[0] && err0_r[15:0] == 16'($past(idx)))
        else $error("error location not captured");
    chk_err_led: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ7
        (launch_rd && (|(bad & MEM_BE))) |-> ##2 ERR_LED)
        else $error("indicator not lit after parity error");
    chk_int_route: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ8
        (stat_r[0] && cfg_r[`PDB_CFG_INT0_EN] && $stable(cfg_r)) |=> INT_LINE[$past(cfg_r[`PDB_CFG_INT0_LO +: 3])])
        else $error("error interrupt not on selected line");
    chk_one_reg: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ9
        (launch_rd && (|(bad & MEM_BE)) && stat_r[0] && !cfg_r[`PDB_CFG_TWO_REGS]) |=> $stable(err1_r))
        else $error("second error register used in single mode");
    chk_read_ack_time: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ13
        (launch_rd && !cfg_r[`PDB_CFG_ADV_EN]) |-> ##CHK_RD_DLY MEM_ACK)
        else $error("read acknowledge not at access time");
    chk_ext_refresh: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RQ11
        (cfg_r[`PDB_CFG_REF_EXT] && REF_EXT_REQ) |=> ref_pend_r || st_r == PDB_REFRESH)
        else $error("external refresh request lost");

    cov_read_err: cover property (@(posedge CLK_SYS) disable iff (!RST_N) launch_rd && (|lane_bad));
    cov_refresh_wait: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        st_r == PDB_REFRESH && MEM_REQ ##[1:20] launch);
    cov_adv_ack: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
        launch_rd && cfg_r[`PDB_CFG_ADV_EN] && adv == 2'b11);
    cov_second_err: cover property (@(posedge CLK_SYS) disable iff (!RST_N) stat_set[1]);
endmodule : pdb_dram_ctrl

// ===== dv/pdb_master.sv
// Bus master model that drives the memory side of the board control
`timescale 1ns/10ps
module pdb_master (
    input  wire logic        clk,
    output logic             req,
    output logic             io,
    output logic             wr,
    output logic      [23:0] addr,
    output logic      [1:0]  be,
    output logic      [15:0] wdata,
    input  wire logic        ack,
    input  wire logic [15:0] rdata
);
    initial begin
        req   = 1'b0;
        io    = 1'b0;
        wr    = 1'b0;
        addr  = 24'h000000;
        be    = 2'b00;
        wdata = 16'h0000;
    end

    // Request held until acknowledge is seen or 200 cycles pass, then dropped for at least one cycle
    task automatic xfer(input logic i, input logic w, input logic [23:0] a, input logic [1:0] b,
                        input logic [15:0] d, output logic [15:0] q, output int n);
        n = 0;
        @(posedge clk);
        req   <= 1'b1;
        io    <= i;
        wr    <= w;
        addr  <= a;
        be    <= b;
        wdata <= d;
        // Acknowledge and read data are taken at the rising edge that samples them
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 200);
        q = rdata;
        req   <= 1'b0;
        // Released address, lane enable and write data lines do not keep the last value
        addr  <= ~a;
        be    <= ~b;
        wdata <= ~d;
        @(posedge clk);
    endtask : xfer
endmodule : pdb_master

// ===== dv/test_parity_dram_board_control.sv
// Self-checking bench for the parity DRAM board control
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t mismatch", $time); end end
module test_parity_dram_board_control;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ref_req = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, led, mreq, mio, mwr, mack;
    logic [11:0] sw = 12'h3a5;
    logic [23:0] maddr;
    logic [1:0]  mbe, par_ext = 2'b00;
    logic [15:0] mwd, mrd, q;
    logic [7:0]  intl;
    logic [31:0] r;
    logic        e;
    int          miscompares = 0, total_checks = 0, n, n0;
    localparam logic [23:0] BASE = 24'h3a5000;

    pdb_dram_ctrl #(.REF_INT(40)) i_dut (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IRQ(irq), .SW_BASE(sw), .MEM_REQ(mreq), .MEM_IO(mio), .MEM_WR(mwr), .MEM_ADDR(maddr), .MEM_BE(mbe),
        .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack), .REF_EXT_REQ(ref_req), .PAR_EXT(par_ext),
        .INT_LINE(intl), .ERR_LED(led));
    pdb_master i_master (.clk(clk), .req(mreq), .io(mio), .wr(mwr), .addr(maddr), .be(mbe), .wdata(mwd),
        .ack(mack), .rdata(mrd));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) miscompares++;
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Let the written register settle before the caller looks at outputs
        @(posedge clk);
    endtask : apb

    task automatic mem(input logic i, input logic w, input logic [23:0] a, input logic [1:0] b,
                       input logic [15:0] d);
        i_master.xfer(i, w, a, b, d, q, n);
    endtask : mem

    task automatic t_regs;
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(r, 32'h0000_0001)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(r, 32'h0)
        apb(1'b1, 8'h40, 32'hffff_ffff);
        `CHK(e, 1'b1)
        $display("t_regs done");
    endtask : t_regs

    task automatic t_data;
        mem(1'b0, 1'b1, BASE + 24'h100, 2'b11, 16'hbeef);
        mem(1'b0, 1'b1, BASE + 24'h102, 2'b11, 16'h55aa);
        mem(1'b0, 1'b1, BASE + 24'h102, 2'b01, 16'hff33);
        mem(1'b0, 1'b0, BASE + 24'h100, 2'b11, 16'h0);
        `CHK(q, 16'hbeef)
        mem(1'b0, 1'b0, BASE + 24'h102, 2'b11, 16'h0);
        `CHK(q, 16'h5533)
        apb(1'b0, 8'h00, 32'h0);
        `CHK(r, 32'h0)
        mem(1'b0, 1'b0, BASE + 24'h8000, 2'b11, 16'h0);
        `CHK(n, 200)
        mem(1'b0, 1'b0, BASE - 24'h1, 2'b11, 16'h0);
        `CHK(n, 200)
        $display("t_data done");
    endtask : t_data

    task automatic t_parity;
        apb(1'b1, 8'h0c, 32'h0042_2bc5);
        mem(1'b0, 1'b1, BASE + 24'h10, 2'b11, 16'h0001);
        mem(1'b0, 1'b1, BASE + 24'h22, 2'b10, 16'h0100);
        apb(1'b1, 8'h0c, 32'h0042_2bc1);
        apb(1'b1, 8'h08, 32'h3);
        mem(1'b0, 1'b0, BASE + 24'h10, 2'b11, 16'h0);
        `CHK(q, 16'h0001)
        `CHK(intl, 8'h08)
        `CHK({irq, led}, 2'b11)
        apb(1'b0, 8'h10, 32'h0);
        `CHK(r, 32'h8001_0008)
        mem(1'b0, 1'b0, BASE + 24'h22, 2'b10, 16'h0);
        apb(1'b0, 8'h14, 32'h0);
        `CHK(r, 32'h8002_0011)
        `CHK(intl, 8'h28)
        mem(1'b1, 1'b0, 24'h000042, 2'b11, 16'h0);
        `CHK(q, 16'h0003)
        apb(1'b1, 8'h08, 32'h0);
        `CHK(irq, 1'b0)
        apb(1'b1, 8'h04, 32'h3);
        repeat (3) @(posedge clk);
        `CHK({irq, led, intl}, 10'h0)
        $display("t_parity done");
    endtask : t_parity

    task automatic t_adv;
        apb(1'b1, 8'h0c, 32'h0000_0002);
        // Let a refresh started by the on-board timer run out
        repeat (20) @(posedge clk);
        mem(1'b0, 1'b0, BASE + 24'h100, 2'b11, 16'h0);
        n0 = n;
        apb(1'b1, 8'h0c, 32'h0000_002a);
        mem(1'b0, 1'b0, BASE + 24'h100, 2'b11, 16'h0);
        `CHK(n0 - n, 2)
        apb(1'b1, 8'h0c, 32'h0000_003a);
        mem(1'b0, 1'b0, BASE + 24'h100, 2'b11, 16'h0);
        `CHK(n0 - n, 3)
        `CHK(q, 16'hbeef)
        apb(1'b1, 8'h0c, 32'h0000_0002);
        @(posedge clk);
        ref_req <= 1'b1;
        @(posedge clk);
        ref_req <= 1'b0;
        mem(1'b0, 1'b0, BASE + 24'h100, 2'b11, 16'h0);
        `CHK(n >= n0 + 12, 1'b1)
        `CHK(q, 16'hbeef)
        $display("t_adv done");
    endtask : t_adv

    task automatic final_report;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_data();
        t_parity();
        t_adv();
        final_report();
    end
endmodule : test_parity_dram_board_control
